// *** logic/bma_defs.svh ***
// Constants for the byte mode operand addressing block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef BMA_DEFS_SVH
`define BMA_DEFS_SVH
// ==========================================
// Register byte offsets on APB
`define BMA_CTRL 8'h00
`define BMA_INSTR 8'h04
`define BMA_PC 8'h08
`define BMA_XREG 8'h0C
`define BMA_AREG 8'h10
`define BMA_STAT 8'h14
`define BMA_ISTAT 8'h18
`define BMA_IMASK 8'h1C
`define BMA_EADDR 8'h20
`define BMA_CYC 8'h24
// ==========================================
// Field positions
`define BMA_CTRL_BYTE 0
`define BMA_CTRL_OVF 1
`define BMA_EV_DONE 0
`define BMA_EV_OVF 1
`define BMA_EV_BAD 2
`define BMA_IND_BIT 8
`define BMA_PTR_CHAIN 15
// ==========================================
// Opcode field, instruction bits 15..11
`define BMA_OP_ADD 5'h11
`define BMA_OP_SUB 5'h12
`define BMA_OP_XOR 5'h15
`define BMA_OP_LOAD 5'h16
`define BMA_OP_STORE 5'h17
`define BMA_OP_SCN 5'h1B
`define BMA_OP_IMS 5'h1C
`define BMA_OP_JMP 5'h1E
`define BMA_OP_JST 5'h1F
// Mode field, instruction bits 10..9
`define BMA_M_SCR 2'h0
`define BMA_M_FWD 2'h1
`define BMA_M_IDX 2'h2
`define BMA_M_BCK 2'h3
// ==========================================
// Reset values and timing counts
`define BMA_RST_W 16'h0000
`define BMA_JST_CYC 2
`endif

// *** logic/bma_pkg.sv ***
// Types shared by the byte mode operand addressing block.
// Assumes nothing of its surroundings.
package bma_pkg;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_PTR = 3'b001,
      ST_OPND = 3'b010,
      ST_WBACK = 3'b011,
      ST_EXEC = 3'b100
   } bma_state_t;
   typedef enum logic [3:0]
   {
      CL_LOAD = 4'h0, CL_ADD = 4'h1, CL_SUB = 4'h2, CL_XOR = 4'h3,
      CL_STORE = 4'h4, CL_JMP = 4'h5, CL_JST = 4'h6, CL_IMS = 4'h7,
      CL_SCN = 4'h8, CL_BAD = 4'h9
   } bma_class_t;
endpackage

// *** logic/bma_ea_if.sv ***
// Carrier between the sequencer and the address former.
// Assumes both ends sit in one clock domain; all signals are combinational.
`timescale 1ns/1ps
interface bma_ea_if;
   logic [15:0] instr;
   logic [15:0] pc;
   logic [15:0] x;
   logic [15:0] ptr;
   logic byteOp;
   logic [14:0] dirWord;
   logic [14:0] ptrWord;
   logic [14:0] finWord;
   logic dirSel;
   logic finSel;
   logic chain;
   modport core (output instr, pc, x, ptr, byteOp,
      input dirWord, ptrWord, finWord, dirSel, finSel, chain);
   modport calc (input instr, pc, x, ptr, byteOp,
      output dirWord, ptrWord, finWord, dirSel, finSel, chain);
endinterface

// *** logic/bma_ea_calc.sv ***
// Effective address former for word and byte operand modes.
// Assumes the sequencer feeds the pointer word read from memory on ptr.
`timescale 1ns/1ps
`include "bma_defs.svh"
module bma_ea_calc
(
   // Sequencer side
   bma_ea_if.calc ea
);
   logic [1:0] mode;
   logic [15:0] dz, fwd, bck, idx, wd, bp, wp;
   assign mode = ea.instr[10:9];
   assign dz = {8'h00, ea.instr[7:0]};

   // Candidate sums, all full 16-bit
   always_comb
   begin
      fwd = ea.pc + 16'h0001 + dz;
      bck = ea.pc - dz;
      idx = dz + ea.x;
      bp = ea.ptr + ((mode == `BMA_M_IDX) ? ea.x : 16'h0000);
      wp = {1'b0, ea.ptr[14:0]} + ((mode == `BMA_M_IDX) ? ea.x : 16'h0000);
      unique case (mode)
         `BMA_M_SCR: wd = dz;
         `BMA_M_FWD: wd = fwd;
         `BMA_M_IDX: wd = idx;
         `BMA_M_BCK: wd = bck;
      endcase
   end

   // Direct target; byte mode has no backward form, 11 means right byte
   always_comb
   begin
      ea.dirWord = wd[14:0];
      ea.dirSel = 1'b0;
      if (ea.byteOp)
      begin
         unique case (mode)
            `BMA_M_SCR:
            begin
               ea.dirWord = dz[15:1];
               ea.dirSel = dz[0];
            end
            `BMA_M_IDX:
            begin
               ea.dirWord = idx[15:1];
               ea.dirSel = idx[0];
            end
            default:
            begin
               ea.dirWord = fwd[14:0];
               ea.dirSel = mode[1];
            end
         endcase
      end
   end

   // Pointer word address, then target taken from the pointer
   always_comb
   begin
      ea.ptrWord = (mode == `BMA_M_IDX) ? dz[14:0] : wd[14:0];
      ea.finWord = ea.byteOp ? bp[15:1] : wp[14:0];
      ea.finSel = ea.byteOp & bp[0];
      ea.chain = ~ea.byteOp & ea.ptr[`BMA_PTR_CHAIN];
   end
endmodule

// *** logic/bma_core.sv ***
// Operand sequencer for memory reference instructions, word and byte mode.
// Assumes an APB master on the register side and a word memory with
// byte lanes that answers each request with a one-cycle ack.
// Overview of operation
// - Jump-store-return writes P+1 at target, then P becomes target plus one.
// - Jump-store-return decodes under all four modes, direct and indirect.
// - Jump-store-return takes two cycles plus one per pointer level.
// - Byte mode gives byte operands except jumps, memory increment and scan.
// - Fetched byte lands in low eight bits, upper eight bits cleared.
// - Byte mode changes only the operand cycle; later work is word-wide.
// - Carries run over 16 bits; overflow flag only on full-word overflow.
// - Byte stores write only the low eight bits of the source register.
// - Unconditional jump always forms a full word address.
// - Byte operand addresses are 16-bit byte addresses over 64K bytes.
// - Byte or word addressing depends on the byte mode indicator and the opcode.
// - Instruction bit 8 clear selects direct addressing.
// - Byte mode 00 uses displacement zero-extended, reaching first 256 bytes.
// - Modes 01 and 11 address word P+1+D, left or right byte.
// - Byte mode has no direct backward relative addressing.
// - Byte mode 10 adds displacement to full 16-bit index register.
// - Indirect byte addressing allows exactly one pointer, optionally indexed.
`timescale 1ns/1ps
`include "bma_defs.svh"
module bma_core
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Memory port
   output logic memReq,
   output logic memWe,
   output logic [14:0] memAddr,
   output logic [1:0] memBe,
   output logic [15:0] memWdata,
   input wire logic memAck,
   input wire logic [15:0] memRdata,
   // Interrupt
   output logic irq
);
   localparam int JST_CYC = `BMA_JST_CYC;
   bma_pkg::bma_state_t state_q;
   bma_pkg::bma_class_t class_q, cls;
   logic pready_q, pslverr_q, memReq_q, memWe_q, irq_q, go_q, byteMode_q;
   logic isByte_q, sel_q, imsZero_q, overflowFlag_q;
   logic [31:0] prdata_q, rdMux;
   logic [14:0] memAddr_q, tgt_q;
   logic [1:0] memBe_q;
   logic [15:0] memWdata_q, instr_q, pc_q, x_q, a_q, opnd, sum, diff;
   logic [2:0] istat_q, imask_q, ev;
   logic [3:0] lvl_q;
   logic [7:0] cycles_q;
   logic hit, apbAcc, apbDone, regWr, busy, exempt, byteDec, launch;
   logic chainMore, opRead, badStart, aluOvf;
   logic [14:0] tgtWord;
   logic tgtSel;
   bma_pkg::bma_class_t runCls;
   logic runByte;

   // ==========================================
   // Address former
   bma_ea_if ea ();
   bma_ea_calc uCalc (.ea(ea.calc));
   assign ea.instr = instr_q;
   assign ea.pc = pc_q;
   assign ea.x = x_q;
   assign ea.ptr = memRdata;
   assign ea.byteOp = (state_q == bma_pkg::ST_IDLE) ? byteDec : isByte_q;
   // Launch from idle sees the fresh decode; latches update on that same edge
   assign runCls = (state_q == bma_pkg::ST_IDLE) ? cls : class_q;
   assign runByte = ea.byteOp;

   // ==========================================
   // Decode: opcode only, byte mode never changes the encoding
   always_comb
   begin
      unique case (instr_q[15:11])
         `BMA_OP_ADD: cls = bma_pkg::CL_ADD;
         `BMA_OP_SUB: cls = bma_pkg::CL_SUB;
         `BMA_OP_XOR: cls = bma_pkg::CL_XOR;
         `BMA_OP_LOAD: cls = bma_pkg::CL_LOAD;
         `BMA_OP_STORE: cls = bma_pkg::CL_STORE;
         `BMA_OP_SCN: cls = bma_pkg::CL_SCN;
         `BMA_OP_IMS: cls = bma_pkg::CL_IMS;
         `BMA_OP_JMP: cls = bma_pkg::CL_JMP;
         `BMA_OP_JST: cls = bma_pkg::CL_JST;
         default: cls = bma_pkg::CL_BAD;
      endcase
   end
   // Jumps, memory increment and scan stay word-wide
   assign exempt = (cls == bma_pkg::CL_JMP) | (cls == bma_pkg::CL_JST) |
      (cls == bma_pkg::CL_IMS) | (cls == bma_pkg::CL_SCN);
   assign byteDec = byteMode_q & ~exempt;
   assign badStart = (state_q == bma_pkg::ST_IDLE) & go_q &
      ((cls == bma_pkg::CL_BAD) | (cls == bma_pkg::CL_SCN));

   // ==========================================
   // Target selection: direct from instruction or final from pointer
   assign chainMore = (state_q == bma_pkg::ST_PTR) & memAck & ea.chain;
   assign tgtWord = (state_q == bma_pkg::ST_PTR) ? ea.finWord : ea.dirWord;
   assign tgtSel = (state_q == bma_pkg::ST_PTR) ? ea.finSel : ea.dirSel;
   assign launch = ((state_q == bma_pkg::ST_IDLE) & go_q & ~badStart &
      ~instr_q[`BMA_IND_BIT]) | ((state_q == bma_pkg::ST_PTR) & memAck &
      ~ea.chain);

   // Byte operand right-justified, upper half cleared
   assign opnd = isByte_q ? {8'h00, sel_q ? memRdata[7:0] : memRdata[15:8]}
      : memRdata;
   // Word-wide arithmetic whatever the operand size
   assign sum = a_q + opnd;
   assign diff = a_q - opnd;
   always_comb
   begin
      aluOvf = 1'b0;
      if (class_q == bma_pkg::CL_ADD)
         aluOvf = (a_q[15] == opnd[15]) & (sum[15] != a_q[15]);
      else if (class_q == bma_pkg::CL_SUB)
         aluOvf = (a_q[15] != opnd[15]) & (diff[15] != a_q[15]);
   end
   assign opRead = (state_q == bma_pkg::ST_OPND) & memAck & ~memWe_q;

   // ==========================================
   // Sequencer and memory request
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state_q <= bma_pkg::ST_IDLE;
         memReq_q <= 1'b0;
         memWe_q <= 1'b0;
         memAddr_q <= 15'h0000;
         memBe_q <= 2'h0;
         memWdata_q <= `BMA_RST_W;
         tgt_q <= 15'h0000;
         sel_q <= 1'b0;
      end
      else if (launch)
      begin
         tgt_q <= tgtWord;
         sel_q <= tgtSel;
         if (runCls == bma_pkg::CL_JMP)
         begin
            memReq_q <= 1'b0;
            state_q <= bma_pkg::ST_EXEC;
         end
         else
         begin
            memReq_q <= 1'b1;
            memWe_q <= (runCls == bma_pkg::CL_STORE) | (runCls == bma_pkg::CL_JST);
            memAddr_q <= tgtWord;
            memBe_q <= runByte ? (tgtSel ? 2'h1 : 2'h2) : 2'h3;
            if (runCls == bma_pkg::CL_JST)
               memWdata_q <= pc_q + 16'h0001;
            else if (runByte)
               memWdata_q <= {a_q[7:0], a_q[7:0]};
            else
               memWdata_q <= a_q;
            state_q <= bma_pkg::ST_OPND;
         end
      end
      else
      begin
         unique case (state_q)
            bma_pkg::ST_IDLE:
            begin
               // Indirect start fetches the first pointer word
               if (go_q && !badStart && instr_q[`BMA_IND_BIT])
               begin
                  memReq_q <= 1'b1;
                  memWe_q <= 1'b0;
                  memAddr_q <= ea.ptrWord;
                  memBe_q <= 2'h3;
                  state_q <= bma_pkg::ST_PTR;
               end
            end
            bma_pkg::ST_PTR:
            begin
               // Word mode may chain; byte mode takes one level only
               if (chainMore)
                  memAddr_q <= memRdata[14:0];
            end
            bma_pkg::ST_OPND:
            begin
               if (memAck && class_q == bma_pkg::CL_IMS)
               begin
                  memWe_q <= 1'b1;
                  memWdata_q <= opnd + 16'h0001;
                  state_q <= bma_pkg::ST_WBACK;
               end
               else if (memAck)
               begin
                  memReq_q <= 1'b0;
                  state_q <= bma_pkg::ST_EXEC;
               end
            end
            bma_pkg::ST_WBACK:
            begin
               if (memAck)
               begin
                  memReq_q <= 1'b0;
                  state_q <= bma_pkg::ST_EXEC;
               end
            end
            bma_pkg::ST_EXEC: state_q <= bma_pkg::ST_IDLE;
            default: state_q <= bma_pkg::ST_IDLE;
         endcase
      end
   end

   // Per-instruction latches, cycle and pointer level counts
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         class_q <= bma_pkg::CL_BAD;
         isByte_q <= 1'b0;
         lvl_q <= 4'h0;
         cycles_q <= 8'h00;
         imsZero_q <= 1'b0;
      end
      else if (state_q == bma_pkg::ST_IDLE && go_q)
      begin
         class_q <= cls;
         isByte_q <= byteDec;
         lvl_q <= 4'h0;
         cycles_q <= 8'h00;
      end
      else
      begin
         if (memAck && memReq_q)
            cycles_q <= cycles_q + 8'h01;
         else if (state_q == bma_pkg::ST_EXEC)
            cycles_q <= cycles_q + 8'h01;
         if (state_q == bma_pkg::ST_PTR && memAck)
            lvl_q <= lvl_q + 4'h1;
         if (state_q == bma_pkg::ST_OPND && memAck)
            imsZero_q <= (opnd + 16'h0001) == 16'h0000;
      end
   end

   // ==========================================
   // APB slave: one wait state so read data leaves a flip-flop
   assign apbAcc = psel & penable & ~pready_q;
   assign apbDone = psel & penable & pready_q;
   assign regWr = apbDone & pwrite & ~pslverr_q;
   assign busy = go_q | (state_q != bma_pkg::ST_IDLE);
   always_comb
   begin
      hit = 1'b1;
      rdMux = 32'h0000_0000;
      unique case (paddr)
         `BMA_CTRL: rdMux = {30'h0, overflowFlag_q, byteMode_q};
         `BMA_INSTR: rdMux = {16'h0000, instr_q};
         `BMA_PC: rdMux = {16'h0000, pc_q};
         `BMA_XREG: rdMux = {16'h0000, x_q};
         `BMA_AREG: rdMux = {16'h0000, a_q};
         `BMA_STAT: rdMux = {28'h0, state_q, busy};
         `BMA_ISTAT: rdMux = {29'h0, istat_q};
         `BMA_IMASK: rdMux = {29'h0, imask_q};
         `BMA_EADDR: rdMux = {16'h0000, isByte_q ? {tgt_q, sel_q} : {1'b0, tgt_q}};
         `BMA_CYC: rdMux = {24'h0, cycles_q};
         default: hit = 1'b0;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= apbAcc;
         pslverr_q <= apbAcc & ~hit;
         if (apbAcc)
            prdata_q <= rdMux;
      end
   end

   // Control bits; hardware overflow set wins over a software clear
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         byteMode_q <= 1'b0;
         overflowFlag_q <= 1'b0;
      end
      else
      begin
         if (regWr && paddr == `BMA_CTRL)
         begin
            byteMode_q <= pwdata[`BMA_CTRL_BYTE];
            overflowFlag_q <= pwdata[`BMA_CTRL_OVF];
         end
         if (opRead && aluOvf)
            overflowFlag_q <= 1'b1;
      end
   end

   // Instruction register; a write while busy is dropped
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         instr_q <= `BMA_RST_W;
         go_q <= 1'b0;
      end
      else if (regWr && paddr == `BMA_INSTR && !busy)
      begin
         instr_q <= pwdata[15:0];
         go_q <= 1'b1;
      end
      else if (state_q == bma_pkg::ST_IDLE)
         go_q <= 1'b0;
   end

   // Index register, software-loaded while idle
   always_ff @(posedge clk)
   begin
      if (!nrst)
         x_q <= `BMA_RST_W;
      else if (regWr && paddr == `BMA_XREG && !busy)
         x_q <= pwdata[15:0];
   end

   // Accumulator and program counter
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         a_q <= `BMA_RST_W;
         pc_q <= `BMA_RST_W;
      end
      else if (!busy)
      begin
         if (regWr && paddr == `BMA_AREG)
            a_q <= pwdata[15:0];
         if (regWr && paddr == `BMA_PC)
            pc_q <= pwdata[15:0];
      end
      else
      begin
         if (opRead)
         begin
            unique case (class_q)
               bma_pkg::CL_LOAD: a_q <= opnd;
               bma_pkg::CL_ADD: a_q <= sum;
               bma_pkg::CL_SUB: a_q <= diff;
               bma_pkg::CL_XOR: a_q <= a_q ^ opnd;
               default: a_q <= a_q;
            endcase
         end
         if (state_q == bma_pkg::ST_EXEC)
         begin
            if (class_q == bma_pkg::CL_JMP)
               pc_q <= {1'b0, tgt_q};
            else if (class_q == bma_pkg::CL_JST)
               pc_q <= {1'b0, tgt_q} + 16'h0001;
            else if (class_q == bma_pkg::CL_IMS && imsZero_q)
               pc_q <= pc_q + 16'h0002;
            else
               pc_q <= pc_q + 16'h0001;
         end
      end
   end

   // ==========================================
   // Interrupts: sticky events, write one to clear, set wins
   assign ev = {badStart, opRead & aluOvf, (state_q == bma_pkg::ST_EXEC) | badStart};
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         istat_q <= 3'h0;
         imask_q <= 3'h0;
         irq_q <= 1'b0;
      end
      else
      begin
         if (regWr && paddr == `BMA_ISTAT)
            istat_q <= (istat_q & ~pwdata[2:0]) | ev;
         else
            istat_q <= istat_q | ev;
         if (regWr && paddr == `BMA_IMASK)
            imask_q <= pwdata[2:0];
         irq_q <= |(istat_q & imask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign memReq = memReq_q;
   assign memWe = memWe_q;
   assign memAddr = memAddr_q;
   assign memBe = memBe_q;
   assign memWdata = memWdata_q;
   assign irq = irq_q;

   // ==========================================
   // Assertions
   a_jst_store: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == bma_pkg::ST_OPND && class_q == bma_pkg::CL_JST)
      |-> memWe_q && memBe_q == 2'h3 && memWdata_q == pc_q + 16'h0001)
      else $error("return link not stored");
   a_jst_jump: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == bma_pkg::ST_EXEC && class_q == bma_pkg::CL_JST)
      |=> pc_q == {1'b0, $past(tgt_q)} + 16'h0001)
      else $error("P not target plus one");
   a_jst_cycles: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == bma_pkg::ST_EXEC && class_q == bma_pkg::CL_JST)
      |=> cycles_q == 8'(JST_CYC) + {4'h0, lvl_q})
      else $error("jump-store cycle count wrong");
   a_exempt_word: assert property (@(posedge clk) disable iff (!nrst)
      (memReq_q && (class_q == bma_pkg::CL_JST || class_q == bma_pkg::CL_IMS))
      |-> memBe_q == 2'h3)
      else $error("exempt op used byte lanes");
   a_byte_zext: assert property (@(posedge clk) disable iff (!nrst)
      (opRead && isByte_q && class_q == bma_pkg::CL_LOAD) |=> a_q[15:8] == 8'h00)
      else $error("byte load not zero-extended");
   a_ovf_full: assert property (@(posedge clk) disable iff (!nrst)
      (opRead && class_q == bma_pkg::CL_ADD && !overflowFlag_q &&
      !(regWr && paddr == `BMA_CTRL))
      |=> overflowFlag_q == (($past(a_q[15]) == $past(opnd[15])) &&
      ($past(sum[15]) != $past(a_q[15]))))
      else $error("overflow flag wrong");
   a_byte_store: assert property (@(posedge clk) disable iff (!nrst)
      (memReq_q && memWe_q && isByte_q)
      |-> memBe_q != 2'h3 && memWdata_q == {a_q[7:0], a_q[7:0]})
      else $error("byte store not low byte");
   a_scr_range: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == bma_pkg::ST_OPND && isByte_q && !instr_q[8] && instr_q[10:9] == 2'h0)
      |-> memAddr_q[14:7] == 8'h00)
      else $error("scratchpad byte out of range");
   a_fwd_left: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == bma_pkg::ST_OPND && isByte_q && !instr_q[8] && instr_q[10:9] == 2'h1)
      |-> memBe_q == 2'h2)
      else $error("mode 01 not left byte");
   a_byte_single: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == bma_pkg::ST_PTR && isByte_q && memAck) |=> state_q != bma_pkg::ST_PTR)
      else $error("byte indirection chained");
   c_jst_ind: cover property (@(posedge clk) disable iff (!nrst)
      state_q == bma_pkg::ST_EXEC && class_q == bma_pkg::CL_JST && lvl_q != 4'h0);
   c_byte_load: cover property (@(posedge clk) disable iff (!nrst)
      opRead && isByte_q && sel_q);
   c_ims_skip: cover property (@(posedge clk) disable iff (!nrst)
      state_q == bma_pkg::ST_EXEC && class_q == bma_pkg::CL_IMS && imsZero_q);
endmodule

// *** sim/bma_mem_model.sv ***
// Word memory with byte lanes, the far side of the operand port.
// Assumes one request at a time, held until the one-cycle ack.
`timescale 1ns/1ps
module bma_mem_model
(
   // Clock
   input wire logic clk,
   // Request
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [14:0] memAddr,
   input wire logic [1:0] memBe,
   input wire logic [15:0] memWdata,
   // Wait states before each ack
   input wire logic [3:0] lat,
   // Answer
   output logic memAck,
   output logic [15:0] memRdata
);
   logic [15:0] mem [0:32767];
   logic [3:0] waitCnt;
   // ==========================================
   // Ack after lat idle cycles; data toggles outside the ack so stale values never match
   initial
   begin
      memAck = 1'h0;
      memRdata = 16'h0000;
      waitCnt = 4'h0;
      for (int i = 0; i < 32768; i++)
         mem[i] = 16'h0000;
   end
   always @(posedge clk)
   begin
      if (!memReq || memAck || waitCnt < lat)
      begin
         memAck <= 1'h0;
         memRdata <= ~memRdata;
         waitCnt <= (!memReq || memAck) ? 4'h0 : waitCnt + 4'h1;
      end
      else
      begin
         memAck <= 1'h1;
         waitCnt <= 4'h0;
         memRdata <= mem[memAddr];
         // Left byte is the upper lane
         if (memWe && memBe[1])
            mem[memAddr][15:8] <= memWdata[15:8];
         if (memWe && memBe[0])
            mem[memAddr][7:0] <= memWdata[7:0];
      end
   end
endmodule

// *** sim/byte_mode_operand_addressing_tb_top.sv ***
// Bench: APB sequences that run instructions against the memory model.
// Assumes the design's register map and opcodes from bma_defs.svh.
`timescale 1ns/1ps
`include "bma_defs.svh"
module byte_mode_operand_addressing_tb_top;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, lastErr;
   logic memReq, memWe, memAck, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdVal;
   logic [14:0] memAddr;
   logic [1:0] memBe;
   logic [15:0] memWdata, memRdata;
   logic [3:0] lat;
   int mismatches, checksDone, cycles;
   logic [15:0] jIns [8] = '{16'hF930, 16'hFB05, 16'hFF05, 16'hFD30,
      16'hF820, 16'hFA05, 16'hFE05, 16'hFC10};
   logic [15:0] jY [8] = '{16'h0200, 16'h0400, 16'h0600, 16'h0500,
      16'h0020, 16'h0106, 16'h00FB, 16'h0310};
   logic [15:0] bIns [6] = '{16'hB021, 16'hB202, 16'hB602, 16'hB403, 16'hB130, 16'hB530};
   logic [15:0] bA [6] = '{16'h00CD, 16'h005A, 16'h003C, 16'h0077, 16'h0099, 16'h0042};
   logic [15:0] bE [6] = '{16'h0021, 16'h0206, 16'h0207, 16'h8004, 16'h0200, 16'h8201};
   bma_core bma_core_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
      .memBe(memBe), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .irq(irq));
   bma_mem_model bma_mem_model_inst (.clk(clk), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memBe(memBe), .memWdata(memWdata), .lat(lat),
      .memAck(memAck), .memRdata(memRdata));
   // ==========================================
   // Clock and hang limit
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finishTest();
      end
   end
   // ==========================================
   // Bus tasks; each ends one edge after release so calls never collide
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rdVal = prdata;
      lastErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      checksDone++;
      if (s !== e)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
      apb(1'h0, a, 16'h0000);
      check(rdVal[15:0], e);
   endtask
   task automatic setup(input logic [15:0] p, input logic [15:0] x, input logic [15:0] a,
      input logic [15:0] c);
      apb(1'h1, `BMA_PC, p);
      apb(1'h1, `BMA_XREG, x);
      apb(1'h1, `BMA_AREG, a);
      apb(1'h1, `BMA_CTRL, c);
   endtask
   // Start, then poll busy with a bounded count
   task automatic exec(input logic [15:0] i);
      apb(1'h1, `BMA_INSTR, i);
      rdVal = 32'h1;
      for (int k = 0; k < 60 && rdVal[0] !== 1'h0; k++)
         apb(1'h0, `BMA_STAT, 16'h0000);
      check({15'h0000, rdVal[0]}, 16'h0000);
   endtask
   task automatic finishTest();
      $display("Checks %0d, mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata, lat} = '0;
      {mismatches, checksDone, cycles} = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      rdChk(`BMA_PC, 16'h0000);
      rdChk(8'h40, 16'h0000);
      check({15'h0000, lastErr}, 16'h0001);
      // Return-jump in every mode, byte mode set; pointer slots first
      bma_mem_model_inst.mem[16'h0030] = 16'h0200;
      bma_mem_model_inst.mem[16'h0106] = 16'h0400;
      bma_mem_model_inst.mem[16'h00FB] = 16'h0600;
      for (int i = 0; i < 8; i++)
      begin
         setup(16'h0100, 16'h0300, 16'h0000, 16'h0001);
         exec(jIns[i]);
         check(bma_mem_model_inst.mem[jY[i]], 16'h0101);
         rdChk(`BMA_PC, jY[i] + 16'h0001);
         rdChk(`BMA_CYC, (i < 4) ? 16'h0003 : 16'h0002);
         lat <= 4'(i);
      end
      // Done event: masked, unmasked, cleared
      check({15'h0000, irq}, 16'h0000);
      apb(1'h1, `BMA_IMASK, 16'h0001);
      @(posedge clk);
      check({15'h0000, irq}, 16'h0001);
      apb(1'h1, `BMA_ISTAT, 16'h0007);
      @(posedge clk);
      check({15'h0000, irq}, 16'h0000);
      // Byte loads through each direct mode and indirect modes 00 and 10
      bma_mem_model_inst.mem[16'h0010] = 16'hABCD;
      bma_mem_model_inst.mem[16'h0103] = 16'h5A3C;
      bma_mem_model_inst.mem[16'h4002] = 16'h7700;
      bma_mem_model_inst.mem[16'h0100] = 16'h9911;
      bma_mem_model_inst.mem[16'h4100] = 16'h0042;
      for (int i = 0; i < 6; i++)
      begin
         setup(16'h0100, 16'h8001, 16'hFFFF, 16'h0001);
         exec(bIns[i]);
         rdChk(`BMA_AREG, bA[i]);
         rdChk(`BMA_EADDR, bE[i]);
      end
      bma_mem_model_inst.mem[16'h0021] = 16'h1357;
      setup(16'h0100, 16'h0000, 16'hFFFF, 16'h0000);
      exec(16'hB021);
      rdChk(`BMA_AREG, 16'h1357);
      // Byte add: full-word overflow versus bit 7 carry
      setup(16'h0100, 16'h0000, 16'h7FFF, 16'h0001);
      exec(16'h8821);
      rdChk(`BMA_AREG, 16'h80CC);
      rdChk(`BMA_CTRL, 16'h0003);
      setup(16'h0100, 16'h0000, 16'h00FF, 16'h0001);
      exec(16'h8821);
      rdChk(`BMA_AREG, 16'h01CC);
      rdChk(`BMA_CTRL, 16'h0001);
      // Byte store, memory increment and plain jump in byte mode
      bma_mem_model_inst.mem[16'h0020] = 16'hAAAA;
      bma_mem_model_inst.mem[16'h0060] = 16'h00FF;
      setup(16'h0100, 16'h0000, 16'h1234, 16'h0001);
      exec(16'hB841);
      check(bma_mem_model_inst.mem[16'h0020], 16'hAA34);
      exec(16'hE060);
      check(bma_mem_model_inst.mem[16'h0060], 16'h0100);
      exec(16'hF055);
      rdChk(`BMA_PC, 16'h0055);
      // Scan is refused: done and unsupported events only
      apb(1'h1, `BMA_ISTAT, 16'h0007);
      exec(16'hDC00);
      rdChk(`BMA_ISTAT, 16'h0005);
      rdChk(`BMA_PC, 16'h0055);
      finishTest();
   end
endmodule
